//--- hdl/tlac_pkg.sv
// Purpose: constants shared by the temperature limit and alert block
// Assumes: 16-bit register words, limits in bits 15:2
// Notes:   field codes are 0.03125 units, margins 0.5 units
package tlac_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 16;
	localparam int          TEMP_W          = 14;
	localparam int          RATE_W          = 13;
	localparam int          MARGIN_W        = 8;

	localparam logic [7:0]  STATUS_OFFSET   = 8'h02;
	localparam logic [7:0]  LOW_OFFSET      = 8'h04;
	localparam logic [7:0]  HIGH_OFFSET     = 8'h05;
	localparam logic [7:0]  MARGIN_OFFSET   = 8'h06;
	localparam logic [7:0]  RATE_OFFSET     = 8'h07;

	localparam logic [15:0] LOW_RESET       = 16'hF380;
	localparam logic [15:0] HIGH_RESET      = 16'h2A80;
	localparam logic [15:0] MARGIN_RESET    = 16'h0A0A;
	localparam logic [15:0] RATE_RESET      = 16'h0500;

	localparam logic [15:0] THR_MASK        = 16'hFFFC;
	localparam logic [15:0] RATE_MASK       = 16'h7FFC;
	localparam logic [15:0] MARGIN_MASK     = 16'hFFFF;

	localparam int          FIELD_LSB       = 2;
	localparam int          HIGH_MARGIN_LSB = 8;
	localparam int          LOW_MARGIN_LSB  = 0;
	localparam int          MARGIN_SHIFT    = 4;

	localparam int          READY_BIT       = 0;
	localparam int          LOW_BIT         = 1;
	localparam int          HIGH_BIT        = 2;
	localparam int          SLEW_BIT        = 3;
	localparam int          IGNORE_BIT      = 4;

	typedef logic [DATA_W-1:0] tlac_word_t;
endpackage

//--- hdl/tlac_cmp_if.sv
// Purpose: carries thresholds and comparison results between modules
// Assumes: one clock domain
// Notes:   ctl side drives settings, cmp side answers
`timescale 1ns/10ps
interface tlac_cmp_if;
	logic signed [13:0] temp;
	logic signed [13:0] rate;
	logic signed [13:0] lowThr;
	logic signed [13:0] highThr;
	logic        [7:0]  highMargin;
	logic        [7:0]  lowMargin;
	logic        [12:0] rateCeil;
	logic               ignore;
	logic               belowLow;
	logic               aboveLowRelease;
	logic               aboveHigh;
	logic               belowHighRelease;
	logic               rateOver;

	modport ctl (
		output temp, rate, lowThr, highThr, highMargin, lowMargin, rateCeil,
		input  ignore, belowLow, aboveLowRelease, aboveHigh, belowHighRelease, rateOver
	);
	modport cmp (
		input  temp, rate, lowThr, highThr, highMargin, lowMargin, rateCeil,
		output ignore, belowLow, aboveLowRelease, aboveHigh, belowHighRelease, rateOver
	);
endinterface

//--- hdl/tlac_limit_cmp.sv
// Purpose: threshold, release and rise-rate comparisons
// Assumes: all values in 0.03125 steps, margins in 0.5 steps
// Notes:   purely combinational
`timescale 1ns/10ps
module tlac_limit_cmp (
	tlac_cmp_if.cmp cmpBus
);
	import tlac_pkg::*;

	function automatic logic signed [16:0] widen(input logic signed [13:0] v);
		widen = 17'(v);
	endfunction

	function automatic logic signed [16:0] margin(input logic [7:0] m);
		margin = $signed({5'h0_0, m, 4'h0});
	endfunction

	wire signed [16:0] tempWide;
	wire signed [16:0] lowWide;
	wire signed [16:0] highWide;
	wire signed [16:0] lowRelease;
	wire signed [16:0] highRelease;
	wire signed [16:0] rateWide;
	wire signed [16:0] ceilWide;

	assign tempWide    = widen(cmpBus.temp);
	assign lowWide     = widen(cmpBus.lowThr);
	assign highWide    = widen(cmpBus.highThr);
	assign highRelease = highWide - margin(cmpBus.highMargin);
	assign lowRelease  = lowWide + margin(cmpBus.lowMargin);
	assign rateWide    = widen(cmpBus.rate);
	assign ceilWide    = $signed({4'h0, cmpBus.rateCeil});

	assign cmpBus.ignore           = highWide <= lowWide;
	assign cmpBus.belowLow         = tempWide < lowWide;
	assign cmpBus.aboveLowRelease  = tempWide > lowRelease;
	assign cmpBus.aboveHigh        = tempWide > highWide;
	assign cmpBus.belowHighRelease = tempWide < highRelease;
	// only a rising rate can exceed an unsigned ceiling
	assign cmpBus.rateOver         = (rateWide > 17'sh0_0000) && (rateWide > ceilWide);
endmodule

//--- hdl/tlac_alert_flag.sv
// Purpose: sticky alert flag with trip and re-arm
// Assumes: evt marks a completed conversion
// Notes:   a set in the clear cycle wins
`timescale 1ns/10ps
module tlac_alert_flag (
	input  wire logic clock,
	input  wire logic rstSync_b,
	input  wire logic evt,
	input  wire logic trip,
	input  wire logic rearm,
	input  wire logic clr,
	output logic      flag
);
	logic armed_reg;
	logic armed_next;
	logic flag_reg;
	logic flag_next;
	wire  setNow;

	assign setNow     = evt && trip && armed_reg;
	// re-arm beats disarm, so a flag with both tied high sets on every event
	assign armed_next = (evt && rearm) ? 1'b1 : (setNow ? 1'b0 : armed_reg);
	assign flag_next  = setNow ? 1'b1 : (clr ? 1'b0 : flag_reg);
	assign flag       = flag_reg;

	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			armed_reg <= 1'b1;
			flag_reg  <= 1'b0;
		end else begin
			armed_reg <= armed_next;
			flag_reg  <= flag_next;
		end
	end
endmodule

//--- hdl/tlac_top.sv
// Purpose: limit, margin and rise-rate registers with alert flags
// Assumes: conversion engine on same clock, one-cycle convDone pulse
// Notes:   register port is the device's internal register access path
// Function
// - low threshold, signed 14-bit, resets to -25
// - high threshold in bits 15:2, resets 85
// - high not above low disables both thresholds
// - reserved bits read zero, ignore writes
// - margins unsigned 8-bit, half degree steps
// - high margin upper byte, low lower byte
// - high release equals high minus margin
// - low release equals low plus margin
// - rate ceiling 13-bit in bits 14:2, resets 10
// - alert only on rising rate above ceiling
// - below-floor flag, re-armed above release, read-clears
`timescale 1ns/10ps
module tlac_top (
	input  wire logic                      clock,
	input  wire logic                      rst_b,
	input  wire logic [tlac_pkg::ADDR_W-1:0] regAddr,
	input  wire logic                      regWrEn,
	input  wire tlac_pkg::tlac_word_t      regWrData,
	input  wire logic                      regRdEn,
	output tlac_pkg::tlac_word_t           regRdData,
	input  wire logic                      convDone,
	input  wire tlac_pkg::tlac_word_t      convTemp,
	input  wire tlac_pkg::tlac_word_t      convRate,
	output logic                           dataReady,
	output logic                           lowFlag,
	output logic                           highFlag,
	output logic                           slewFlag,
	output logic                           limitsIgnored
);
	import tlac_pkg::*;

	// reset release
	logic       rstMeta_reg;
	logic       rstSync_reg;
	wire        rstSync_b;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end

	assign rstSync_b = rstSync_reg;

	// address decode
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	wire        selStatus;
	wire        selLow;
	wire        selHigh;
	wire        selMargin;
	wire        selRate;
	wire        wrLow;
	wire        wrHigh;
	wire        wrMargin;
	wire        wrRate;
	wire        statusRead;

	assign selStatus  = hit(regAddr, STATUS_OFFSET);
	assign selLow     = hit(regAddr, LOW_OFFSET);
	assign selHigh    = hit(regAddr, HIGH_OFFSET);
	assign selMargin  = hit(regAddr, MARGIN_OFFSET);
	assign selRate    = hit(regAddr, RATE_OFFSET);
	assign wrLow      = regWrEn && selLow;
	assign wrHigh     = regWrEn && selHigh;
	assign wrMargin   = regWrEn && selMargin;
	assign wrRate     = regWrEn && selRate;
	assign statusRead = regRdEn && selStatus;

	// settings registers
	tlac_word_t lowThreshold_reg;
	tlac_word_t lowThreshold_next;
	tlac_word_t highThreshold_reg;
	tlac_word_t highThreshold_next;
	tlac_word_t margin_reg;
	tlac_word_t margin_next;
	tlac_word_t rateCeil_reg;
	tlac_word_t rateCeil_next;

	assign lowThreshold_next  = wrLow ? (regWrData & THR_MASK) : lowThreshold_reg;
	assign highThreshold_next = wrHigh ? (regWrData & THR_MASK) : highThreshold_reg;
	assign margin_next        = wrMargin ? (regWrData & MARGIN_MASK) : margin_reg;
	assign rateCeil_next      = wrRate ? (regWrData & RATE_MASK) : rateCeil_reg;

	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			lowThreshold_reg  <= LOW_RESET;
			highThreshold_reg <= HIGH_RESET;
			margin_reg        <= MARGIN_RESET;
			rateCeil_reg      <= RATE_RESET;
		end else begin
			lowThreshold_reg  <= lowThreshold_next;
			highThreshold_reg <= highThreshold_next;
			margin_reg        <= margin_next;
			rateCeil_reg      <= rateCeil_next;
		end
	end

	// comparison path
	tlac_cmp_if cmpBus ();

	assign cmpBus.temp       = $signed(convTemp[DATA_W-1:FIELD_LSB]);
	assign cmpBus.rate       = $signed(convRate[DATA_W-1:FIELD_LSB]);
	assign cmpBus.lowThr     = $signed(lowThreshold_reg[DATA_W-1:FIELD_LSB]);
	assign cmpBus.highThr    = $signed(highThreshold_reg[DATA_W-1:FIELD_LSB]);
	assign cmpBus.highMargin = margin_reg[HIGH_MARGIN_LSB +: MARGIN_W];
	assign cmpBus.lowMargin  = margin_reg[LOW_MARGIN_LSB +: MARGIN_W];
	assign cmpBus.rateCeil   = rateCeil_reg[FIELD_LSB +: RATE_W];

	tlac_limit_cmp limitCmp (
		.cmpBus (cmpBus.cmp)
	);

	// alert flags, evaluated on each conversion
	wire        lowTrip;
	wire        lowRearm;
	wire        highTrip;
	wire        highRearm;

	assign lowTrip   = !cmpBus.ignore && cmpBus.belowLow;
	assign lowRearm  = !cmpBus.ignore && cmpBus.aboveLowRelease;
	assign highTrip  = !cmpBus.ignore && cmpBus.aboveHigh;
	assign highRearm = !cmpBus.ignore && cmpBus.belowHighRelease;

	tlac_alert_flag readyFlag (
		.clock     (clock),
		.rstSync_b (rstSync_b),
		.evt       (convDone),
		.trip      (1'b1),
		.rearm     (1'b1),
		.clr       (statusRead),
		.flag      (dataReady)
	);

	tlac_alert_flag floorFlag (
		.clock     (clock),
		.rstSync_b (rstSync_b),
		.evt       (convDone),
		.trip      (lowTrip),
		.rearm     (lowRearm),
		.clr       (statusRead),
		.flag      (lowFlag)
	);

	tlac_alert_flag ceilFlag (
		.clock     (clock),
		.rstSync_b (rstSync_b),
		.evt       (convDone),
		.trip      (highTrip),
		.rearm     (highRearm),
		.clr       (statusRead),
		.flag      (highFlag)
	);

	tlac_alert_flag rateFlag (
		.clock     (clock),
		.rstSync_b (rstSync_b),
		.evt       (convDone),
		.trip      (cmpBus.rateOver),
		.rearm     (!cmpBus.rateOver),
		.clr       (statusRead),
		.flag      (slewFlag)
	);

	assign limitsIgnored = cmpBus.ignore;

	// read path
	tlac_word_t statusWord;
	tlac_word_t readMux;
	tlac_word_t regRdData_reg;
	tlac_word_t regRdData_next;

	always_comb begin
		statusWord             = '0;
		statusWord[READY_BIT]  = dataReady;
		statusWord[LOW_BIT]    = lowFlag;
		statusWord[HIGH_BIT]   = highFlag;
		statusWord[SLEW_BIT]   = slewFlag;
		statusWord[IGNORE_BIT] = cmpBus.ignore;
	end

	assign readMux = selStatus ? statusWord :
		selLow    ? lowThreshold_reg :
		selHigh   ? highThreshold_reg :
		selMargin ? margin_reg :
		selRate   ? rateCeil_reg : '0;

	assign regRdData_next = regRdEn ? readMux : regRdData_reg;
	assign regRdData      = regRdData_reg;

	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			regRdData_reg <= '0;
		end else begin
			regRdData_reg <= regRdData_next;
		end
	end
endmodule

//--- verification/tlac_top_assertions.sv
// Purpose: port checks for tlac_top
// Assumes: one clock, status word at STATUS_OFFSET
// Notes:   bound into every tlac_top
`timescale 1ns/10ps
module tlac_top_assertions (
	input wire logic                         clock,
	input wire logic                         rst_b,
	input wire logic [tlac_pkg::ADDR_W-1:0]  regAddr,
	input wire logic                         regWrEn,
	input wire logic                         regRdEn,
	input wire tlac_pkg::tlac_word_t         regRdData,
	input wire logic                         convDone,
	input wire tlac_pkg::tlac_word_t         convRate,
	input wire logic                         dataReady,
	input wire logic                         lowFlag,
	input wire logic                         highFlag,
	input wire logic                         slewFlag,
	input wire logic                         limitsIgnored
);
	import tlac_pkg::*;
	wire logic statRd = regRdEn && (regAddr == STATUS_OFFSET);
	wire logic limRd  = regRdEn && (regAddr inside {LOW_OFFSET, HIGH_OFFSET, RATE_OFFSET});
	wire logic [4:0] statNow = {limitsIgnored, slewFlag, highFlag, lowFlag, dataReady};
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	ready_on_conv_a: assert property (convDone |=> dataReady)
		else $error("ready not set after conversion");
	status_clear_a: assert property (statRd && !convDone |=> !(dataReady || lowFlag || highFlag || slewFlag))
		else $error("status read did not clear flags");
	status_view_a: assert property (statRd |=> regRdData[4:0] == $past(statNow))
		else $error("status word wrong");
	reserved_zero_a: assert property (limRd |=> regRdData[1:0] == 2'h0)
		else $error("reserved low bits not zero");
	rate_top_a: assert property (regRdEn && regAddr == RATE_OFFSET |=> !regRdData[15])
		else $error("rate ceiling top bit set");
	low_sticky_a: assert property (lowFlag && !statRd |=> lowFlag)
		else $error("low flag dropped without read");
	low_quiet_a: assert property (!convDone && !lowFlag |=> !lowFlag)
		else $error("low flag set without conversion");
	ignore_hold_a: assert property (limitsIgnored && !regWrEn && !highFlag |=> !highFlag)
		else $error("high flag set while limits ignored");
	fall_quiet_a: assert property (convDone && convRate[15] && !slewFlag |=> !slewFlag)
		else $error("slew flag set on falling rate");
endmodule
bind tlac_top tlac_top_assertions tlac_top_assertions_inst (.clock(clock), .rst_b(rst_b),
	.regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
	.convDone(convDone), .convRate(convRate), .dataReady(dataReady), .lowFlag(lowFlag),
	.highFlag(highFlag), .slewFlag(slewFlag), .limitsIgnored(limitsIgnored));

//--- verification/tlac_host_model.sv
// Purpose: host side of the register access path
// Assumes: one-cycle strobes, read data one cycle later
// Notes:   address and write data inverted once released
`timescale 1ns/10ps
module tlac_host_model (
	input  wire logic                        clock,
	output logic [tlac_pkg::ADDR_W-1:0]      regAddr,
	output logic                             regWrEn,
	output tlac_pkg::tlac_word_t             regWrData,
	output logic                             regRdEn,
	input  wire tlac_pkg::tlac_word_t        regRdData
);
	import tlac_pkg::*;
	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 16'h0000;
		regRdEn = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input tlac_word_t d);
		@(posedge clock);
		#1;
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge clock);
		#1;
		regWrEn = 1'b0;
		regWrData = ~d;
		regAddr = ~a;
	endtask
	task automatic rd(input logic [7:0] a, output tlac_word_t d);
		@(posedge clock);
		#1;
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge clock);
		#1;
		regRdEn = 1'b0;
		d = regRdData;
		regAddr = ~a;
	endtask
endmodule

//--- verification/temp_limit_alert_config_tb_top.sv
// Purpose: self-checking bench for tlac_top
// Assumes: flags settle one cycle after convDone
// Notes:   temps given as full register words
`timescale 1ns/10ps
module temp_limit_alert_config_tb_top;
	import tlac_pkg::*;
	logic              clock;
	logic              rst_b;
	logic              convDone;
	tlac_word_t        convTemp;
	tlac_word_t        convRate;
	logic [ADDR_W-1:0] regAddr;
	logic              regWrEn;
	logic              regRdEn;
	tlac_word_t        regWrData;
	tlac_word_t        regRdData;
	logic              dataReady;
	logic              lowFlag;
	logic              highFlag;
	logic              slewFlag;
	logic              limitsIgnored;
	int                failures;
	int                total_checks;
	logic [7:0]        offs [4] = '{8'h04, 8'h05, 8'h06, 8'h07};
	tlac_word_t        rsts [4] = '{16'hF380, 16'h2A80, 16'h0A0A, 16'h0500};
	tlac_word_t        masks[4] = '{16'hFFFC, 16'hFFFC, 16'hFFFF, 16'h7FFC};
	tlac_top tlac_top_inst (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.convDone(convDone), .convTemp(convTemp), .convRate(convRate), .dataReady(dataReady),
		.lowFlag(lowFlag), .highFlag(highFlag), .slewFlag(slewFlag),
		.limitsIgnored(limitsIgnored));
	tlac_host_model tlac_host_model_inst (.clock(clock), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
	task automatic chk(input tlac_word_t got, input tlac_word_t exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input tlac_word_t exp);
		tlac_word_t v;
		tlac_host_model_inst.rd(a, v);
		chk(v, exp);
	endtask
	task automatic conv(input tlac_word_t t, input tlac_word_t r);
		@(posedge clock);
		#1;
		convDone = 1'b1;
		convTemp = t;
		convRate = r;
		@(posedge clock);
		#1;
		convDone = 1'b0;
		convTemp = ~t;
	endtask
	task automatic fl(input logic f, input logic e);
		chk({15'h0000, f}, {15'h0000, e});
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		#200000;
		failures++;
		finish_test();
	end
	initial begin
		rst_b = 1'b0;
		convDone = 1'b0;
		convTemp = 16'h0000;
		convRate = 16'h0000;
		failures = 0;
		total_checks = 0;
		repeat (8) @(posedge clock);
		#1;
		rst_b = 1'b1;
		repeat (3) @(posedge clock);
		foreach (offs[i]) begin
			rchk(offs[i], rsts[i]);
			tlac_host_model_inst.wr(offs[i], 16'hFFFF);
			rchk(offs[i], masks[i]);
			tlac_host_model_inst.wr(offs[i], rsts[i]);
		end
		rchk(8'h3C, 16'h0000);
		$display("test registers done");
		tlac_host_model_inst.wr(HIGH_OFFSET, 16'hF380);
		fl(limitsIgnored, 1'b1);
		conv(16'hF37C, 16'h0000);
		fl(lowFlag, 1'b0);
		tlac_host_model_inst.wr(HIGH_OFFSET, 16'h2A80);
		fl(limitsIgnored, 1'b0);
		rchk(STATUS_OFFSET, 16'h0001);
		$display("test ignore done");
		conv(16'hF37C, 16'h0000);
		fl(lowFlag, 1'b1);
		rchk(STATUS_OFFSET, 16'h0003);
		conv(16'hF37C, 16'h0000);
		conv(16'hF600, 16'h0000);
		conv(16'hF37C, 16'h0000);
		fl(lowFlag, 1'b0);
		conv(16'hF604, 16'h0000);
		conv(16'hF37C, 16'h0000);
		fl(lowFlag, 1'b1);
		rchk(STATUS_OFFSET, 16'h0003);
		$display("test low done");
		conv(16'h2A84, 16'h0000);
		rchk(STATUS_OFFSET, 16'h0005);
		conv(16'h2A84, 16'h0000);
		conv(16'h2800, 16'h0000);
		conv(16'h2A84, 16'h0000);
		fl(highFlag, 1'b0);
		conv(16'h27FC, 16'h0000);
		conv(16'h2A84, 16'h0000);
		fl(highFlag, 1'b1);
		rchk(STATUS_OFFSET, 16'h0005);
		tlac_host_model_inst.wr(MARGIN_OFFSET, 16'h140A);
		conv(16'h2700, 16'h0000);
		conv(16'h2A84, 16'h0000);
		fl(highFlag, 1'b0);
		conv(16'h257C, 16'h0000);
		conv(16'h2A84, 16'h0000);
		fl(highFlag, 1'b1);
		rchk(STATUS_OFFSET, 16'h0005);
		$display("test high done");
		conv(16'h0000, 16'h0500);
		fl(slewFlag, 1'b0);
		conv(16'h0000, 16'h0504);
		rchk(STATUS_OFFSET, 16'h0009);
		conv(16'h0000, 16'hF000);
		fl(slewFlag, 1'b0);
		conv(16'h0000, 16'h0504);
		fl(slewFlag, 1'b1);
		$display("test slew done");
		finish_test();
	end
endmodule
